// [isasr_core.sv]
// Indirect store/load execution, indirect port aliasing and software reset.
`timescale 1ns/100ps
`default_nettype none
module isasr_core
	import isasr_pkg::*;
#(
	parameter int unsigned DATA_WIDTH = DATA_W
)
(
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  instr_valid_i,
	input  wire logic [OP_W-1:0]       instr_op_i,
	input  wire logic                  ptr_sel_i,
	input  wire logic                  rel_form_i,
	input  wire logic [1:0]            pointer_update_mode_i,
	input  wire logic [OFS_W-1:0]      offset_i,
	input  wire logic [DATA_WIDTH-1:0] accumulator_i,
	input  wire logic                  port_access_i,
	input  wire logic                  port_sel_i,
	input  wire logic                  port_write_i,
	input  wire logic [DATA_WIDTH-1:0] port_wdata_i,
	input  wire logic                  ptr_load_i,
	input  wire logic                  ptr_load_sel_i,
	input  wire logic [PTR_W-1:0]      ptr_load_data_i,
	input  wire logic [DATA_WIDTH-1:0] mem_rdata_i,
	output logic                       ready_o,
	output logic [PTR_W-1:0]           mem_addr_o,
	output logic                       mem_we_o,
	output logic                       mem_re_o,
	output logic [DATA_WIDTH-1:0]      mem_wdata_o,
	output logic                       acc_we_o,
	output logic [DATA_WIDTH-1:0]      acc_wdata_o,
	output logic                       zero_we_o,
	output logic                       zero_o,
	output logic [PTR_W-1:0]           file_select_pointer0_o,
	output logic [PTR_W-1:0]           file_select_pointer1_o,
	output logic                       soft_reset_o,
	output logic                       reset_instruction_flag_clr_o
);

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	if (DATA_WIDTH < 1 || DATA_WIDTH > 32)
	begin : g_bad_width
		$error("DATA_WIDTH must lie between 1 and 32");
	end

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	isasr_state_t          state_ff;
	logic [PTR_W-1:0]      ptr_ff [2];
	logic                  ready_ff;
	logic                  take;
	logic                  take_store;
	logic                  take_load;
	logic                  take_reset;
	logic                  take_nop;
	logic                  take_port;
	logic [PTR_W-1:0]      sel_ptr;
	logic [PTR_W-1:0]      ea;
	logic [PTR_W-1:0]      nxt_ptr;

	// Accesses to the alias addresses arrive as port_access_i; there is no
	// register file here for them, only the pointer redirect.
	assign take       = instr_valid_i && ready_ff;
	assign take_store = take && (instr_op_i == OP_STORE_IND);
	assign take_load  = take && (instr_op_i == OP_LOAD_IND);
	assign take_reset = take && (instr_op_i == OP_SOFT_RESET);
	assign take_nop   = take && (instr_op_i == OP_NO_OPERATION);
	assign take_port  = ready_ff && port_access_i && !instr_valid_i;
	assign sel_ptr    = ptr_ff[ptr_sel_i];

	isasr_ptr_calc u_calc
	(
		.ptr_i     (sel_ptr),
		.mode_i    (pointer_update_mode_i),
		.rel_i     (rel_form_i),
		.offset_i  (offset_i),
		.ea_o      (ea),
		.nxt_ptr_o (nxt_ptr)
	);

	// ------------------------------------------------------------------
	// Execution stage
	// ------------------------------------------------------------------
	// A load holds the decode port for one extra cycle while data returns.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			state_ff <= ST_IDLE;
			ready_ff <= 1'b1;
		end
		else
		begin
			unique case (state_ff)
				ST_IDLE:
				begin
					if (take_load)
					begin
						state_ff <= ST_READ;
						ready_ff <= 1'b0;
					end
				end
				ST_READ:
				begin
					state_ff <= ST_IDLE;
					ready_ff <= 1'b1;
				end
				default:
				begin
					state_ff <= ST_IDLE;
					ready_ff <= 1'b1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Pointers
	// ------------------------------------------------------------------
	// Indirect moves take priority over a plain pointer write in the same cycle.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			ptr_ff[0] <= PTR_RST;
			ptr_ff[1] <= PTR_RST;
		end
		else if (take_store || take_load)
		begin
			ptr_ff[ptr_sel_i] <= nxt_ptr;
		end
		else if (ptr_load_i)
		begin
			ptr_ff[ptr_load_sel_i] <= ptr_load_data_i;
		end
	end

	// ------------------------------------------------------------------
	// Memory port
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			mem_addr_o  <= PTR_RST;
			mem_we_o    <= 1'b0;
			mem_re_o    <= 1'b0;
			mem_wdata_o <= DATA_WIDTH'(DATA_RST);
		end
		else
		begin
			mem_we_o <= take_store || (take_port && port_write_i);
			mem_re_o <= take_load || (take_port && !port_write_i);
			if (take_store || take_load)
			begin
				mem_addr_o <= ea;
			end
			else if (take_port)
			begin
				mem_addr_o <= ptr_ff[port_sel_i];
			end
			if (take_store)
			begin
				mem_wdata_o <= accumulator_i;
			end
			else if (take_port)
			begin
				mem_wdata_o <= port_wdata_i;
			end
		end
	end

	// ------------------------------------------------------------------
	// Accumulator and zero flag write-back
	// ------------------------------------------------------------------
	// Only the load touches a flag; stores and pointer steps leave them alone.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			acc_we_o    <= 1'b0;
			acc_wdata_o <= DATA_WIDTH'(DATA_RST);
			zero_we_o   <= 1'b0;
			zero_o      <= 1'b0;
		end
		else
		begin
			acc_we_o  <= (state_ff == ST_READ);
			zero_we_o <= (state_ff == ST_READ);
			if (state_ff == ST_READ)
			begin
				acc_wdata_o <= mem_rdata_i;
				zero_o      <= (mem_rdata_i == '0);
			end
		end
	end

	// ------------------------------------------------------------------
	// Software reset
	// ------------------------------------------------------------------
	// One-cycle request; the reset controller stretches it and resets us too.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			soft_reset_o                 <= 1'b0;
			reset_instruction_flag_clr_o <= 1'b0;
		end
		else
		begin
			soft_reset_o                 <= take_reset;
			reset_instruction_flag_clr_o <= take_reset;
		end
	end

	assign ready_o                = ready_ff;
	assign file_select_pointer0_o = ptr_ff[0];
	assign file_select_pointer1_o = ptr_ff[1];

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	AST_STORE_WRITE: assert property (take_store |=> mem_we_o && mem_wdata_o == $past(accumulator_i)
		&& mem_addr_o == $past(ea))
		else $error("indirect store did not write accumulator to effective address");

	AST_PORT_ALIAS: assert property (take_port |=> mem_addr_o == $past(ptr_ff[port_sel_i])
		&& (mem_we_o == $past(port_write_i)))
		else $error("indirect port access not redirected through pointer");

	AST_NO_STRAY_WRITE: assert property (mem_we_o |-> $past(take_store) || $past(take_port))
		else $error("memory write without indirect store or port access");

	AST_PREINC_ADDR: assert property (take_store && !rel_form_i
		&& pointer_update_mode_i == MODE_PRE_INC |=> mem_addr_o == PTR_W'($past(sel_ptr) + 16'h0001))
		else $error("preincrement address wrong");

	AST_REL_ADDR: assert property ((take_store || take_load) && rel_form_i |=> mem_addr_o ==
		PTR_W'($past(sel_ptr) + {{(PTR_W-OFS_W){$past(offset_i[OFS_W-1])}}, $past(offset_i)}))
		else $error("relative offset address wrong");

	AST_REL_PTR_HOLD: assert property ((take_store || take_load) && rel_form_i && !ptr_load_i
		|=> $stable(ptr_ff[0]) && $stable(ptr_ff[1]))
		else $error("relative form moved a pointer");

	AST_POSTDEC_WRAP: assert property (take_store && !rel_form_i && !ptr_sel_i && ptr_ff[0] == 16'h0000
		&& pointer_update_mode_i == MODE_POST_DEC |=> ptr_ff[0] == 16'hffff && mem_addr_o == 16'h0000)
		else $error("pointer did not wrap below zero");

	AST_STORE_NO_FLAG: assert property (take_store |=> !zero_we_o [*2])
		else $error("indirect store touched a status flag");

	AST_SOFT_RESET: assert property (take_reset |=> soft_reset_o ##1 !soft_reset_o)
		else $error("software reset request not a single pulse");

	AST_RI_CLEAR: assert property (reset_instruction_flag_clr_o == soft_reset_o)
		else $error("reset flag clear not aligned with software reset");

	AST_LOAD_WB: assert property (take_load |=> mem_re_o && !ready_o ##1 acc_we_o && zero_we_o
		&& zero_o == (acc_wdata_o == '0) && ready_o)
		else $error("indirect load write-back wrong");

	AST_NOP_QUIET: assert property (take_nop && !ptr_load_i |=> !mem_we_o && !mem_re_o && !acc_we_o
		&& !zero_we_o && ready_o && $stable(ptr_ff[0]) && $stable(ptr_ff[1]))
		else $error("no-operation changed state");

	COV_STORE_POSTINC: cover property (take_store && !rel_form_i && pointer_update_mode_i == MODE_POST_INC);
	COV_LOAD_ZERO: cover property (take_load ##2 zero_o);
	COV_SOFT_RESET: cover property (take_reset ##1 soft_reset_o);
	COV_PORT_WRITE: cover property (take_port && port_write_i);

endmodule
`default_nettype wire

// [isasr_pkg.sv]
// Shared constants and types for the indirect store and software reset slice.
`default_nettype none
package isasr_pkg;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int unsigned PTR_W  = 16;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned OFS_W  = 6;
	localparam int unsigned OP_W   = 3;

	// ------------------------------------------------------------------
	// Pointer update mode field codes
	// ------------------------------------------------------------------
	localparam logic [1:0] MODE_PRE_INC  = 2'h0;
	localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
	localparam logic [1:0] MODE_POST_INC = 2'h2;
	localparam logic [1:0] MODE_POST_DEC = 2'h3;

	// ------------------------------------------------------------------
	// Instruction class codes on the decode port
	// ------------------------------------------------------------------
	localparam logic [OP_W-1:0] OP_NO_OPERATION = 3'h0;
	localparam logic [OP_W-1:0] OP_STORE_IND    = 3'h1;
	localparam logic [OP_W-1:0] OP_LOAD_IND     = 3'h2;
	localparam logic [OP_W-1:0] OP_SOFT_RESET   = 3'h3;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [PTR_W-1:0]  PTR_RST  = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

	// ------------------------------------------------------------------
	// Execution stage, one-hot
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_READ = 2'b10
	} isasr_state_t;

endpackage
`default_nettype wire

// [isasr_ptr_calc.sv]
// Effective address and pointer update arithmetic for indirect moves.
`timescale 1ns/100ps
`default_nettype none
module isasr_ptr_calc
	import isasr_pkg::*;
(
	input  wire logic [PTR_W-1:0] ptr_i,
	input  wire logic [1:0]       mode_i,
	input  wire logic             rel_i,
	input  wire logic [OFS_W-1:0] offset_i,
	output logic      [PTR_W-1:0] ea_o,
	output logic      [PTR_W-1:0] nxt_ptr_o
);

	// ------------------------------------------------------------------
	// Adjusted values
	// ------------------------------------------------------------------
	// Plain modulo arithmetic gives the wrap at both bounds for free.
	logic [PTR_W-1:0] inc_ptr;
	logic [PTR_W-1:0] dec_ptr;
	logic [PTR_W-1:0] rel_ptr;
	assign inc_ptr = PTR_W'(ptr_i + 16'h0001);
	assign dec_ptr = PTR_W'(ptr_i - 16'h0001);
	assign rel_ptr = PTR_W'(ptr_i + {{(PTR_W-OFS_W){offset_i[OFS_W-1]}}, offset_i});

	// ------------------------------------------------------------------
	// Mode selection
	// ------------------------------------------------------------------
	// Relative form never moves the pointer; other forms differ in timing and direction.
	always_comb
	begin
		ea_o      = ptr_i;
		nxt_ptr_o = ptr_i;
		if (rel_i)
		begin
			ea_o = rel_ptr;
		end
		else
		begin
			unique case (mode_i)
				MODE_PRE_INC:
				begin
					ea_o      = inc_ptr;
					nxt_ptr_o = inc_ptr;
				end
				MODE_PRE_DEC:
				begin
					ea_o      = dec_ptr;
					nxt_ptr_o = dec_ptr;
				end
				MODE_POST_INC:
				begin
					nxt_ptr_o = inc_ptr;
				end
				MODE_POST_DEC:
				begin
					nxt_ptr_o = dec_ptr;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// [isasr_tb_top.sv]
// Self-checking testbench for the indirect store, indirect load and software reset slice.
`timescale 1ns/100ps
`default_nettype none
module isasr_tb_top
	import isasr_pkg::*;
;
	// ------------------------------------------------------------------
	// Stimulus signals and counters
	// ------------------------------------------------------------------
	logic               ref_clk_i = 1'b0;
	logic               rst_i = 1'b1;
	logic               instr_valid_i = 1'b0;
	logic [OP_W-1:0]    instr_op_i = OP_NO_OPERATION;
	logic               ptr_sel_i = 1'b0;
	logic               rel_form_i = 1'b0;
	logic [1:0]         pointer_update_mode_i = 2'h0;
	logic [OFS_W-1:0]   offset_i = 6'h00;
	logic [7:0]         accumulator_i = 8'h00;
	logic               port_access_i = 1'b0;
	logic               port_sel_i = 1'b0;
	logic               port_write_i = 1'b0;
	logic [7:0]         port_wdata_i = 8'h00;
	logic               ptr_load_i = 1'b0;
	logic               ptr_load_sel_i = 1'b0;
	logic [PTR_W-1:0]   ptr_load_data_i = 16'h0000;
	logic [7:0]         mem_rdata_i = 8'h00;
	logic               ready_o;
	logic [PTR_W-1:0]   mem_addr_o;
	logic               mem_we_o;
	logic               mem_re_o;
	logic [7:0]         mem_wdata_o;
	logic               acc_we_o;
	logic [7:0]         acc_wdata_o;
	logic               zero_we_o;
	logic               zero_o;
	logic [PTR_W-1:0]   file_select_pointer0_o;
	logic [PTR_W-1:0]   file_select_pointer1_o;
	logic               soft_reset_o;
	logic               reset_instruction_flag_clr_o;
	int                 n_fail = 0;
	int                 total_checks = 0;

	isasr_core DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i),
		.ptr_sel_i(ptr_sel_i), .rel_form_i(rel_form_i), .pointer_update_mode_i(pointer_update_mode_i),
		.offset_i(offset_i), .accumulator_i(accumulator_i), .port_access_i(port_access_i), .port_sel_i(port_sel_i),
		.port_write_i(port_write_i), .port_wdata_i(port_wdata_i), .ptr_load_i(ptr_load_i),
		.ptr_load_sel_i(ptr_load_sel_i), .ptr_load_data_i(ptr_load_data_i), .mem_rdata_i(mem_rdata_i),
		.ready_o(ready_o), .mem_addr_o(mem_addr_o), .mem_we_o(mem_we_o), .mem_re_o(mem_re_o),
		.mem_wdata_o(mem_wdata_o), .acc_we_o(acc_we_o), .acc_wdata_o(acc_wdata_o), .zero_we_o(zero_we_o),
		.zero_o(zero_o), .file_select_pointer0_o(file_select_pointer0_o),
		.file_select_pointer1_o(file_select_pointer1_o), .soft_reset_o(soft_reset_o),
		.reset_instruction_flag_clr_o(reset_instruction_flag_clr_o));

	// The clock toggles every half period of 4 ns, giving an 8 ns period.
	initial
	begin
		forever #4 ref_clk_i = ~ref_clk_i;
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	// Compares with case inequality so that an unknown never passes.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("FAIL at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic conclude();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Presents one instruction for one cycle; returns settled in the cycle after the take.
	task automatic issue(input logic [2:0] op, input logic sel, input logic rel, input logic [1:0] md,
		input logic [5:0] ofs, input logic [7:0] acc);
		@(posedge ref_clk_i);
		instr_valid_i <= 1'b1;
		instr_op_i <= op;
		ptr_sel_i <= sel;
		rel_form_i <= rel;
		pointer_update_mode_i <= md;
		offset_i <= ofs;
		accumulator_i <= acc;
		@(posedge ref_clk_i);
		instr_valid_i <= 1'b0;
		#1;
	endtask

	// Writes a pointer through the plain pointer write port.
	task automatic set_ptr(input logic sel, input logic [15:0] val);
		@(posedge ref_clk_i);
		ptr_load_i <= 1'b1;
		ptr_load_sel_i <= sel;
		ptr_load_data_i <= val;
		@(posedge ref_clk_i);
		ptr_load_i <= 1'b0;
		#1;
	endtask

	// One store with its address, data, pointer update and untouched flags judged.
	task automatic do_store(input logic sel, input logic rel, input logic [1:0] md, input logic [5:0] ofs,
		input logic [15:0] exp_addr, input logic [15:0] exp_ptr);
		issue(OP_STORE_IND, sel, rel, md, ofs, 8'h5a);
		chk(16'(mem_we_o), 16'h0001, "store strobe"); // Write strobe
		chk(mem_addr_o, exp_addr, "store address"); // Effective address
		chk(16'(mem_wdata_o), 16'h005a, "store data"); // Accumulator data
		chk(sel ? file_select_pointer1_o : file_select_pointer0_o, exp_ptr, "pointer after"); // Update
		chk(16'({zero_we_o, acc_we_o}), 16'h0000, "flags touched"); // No status change
		@(posedge ref_clk_i);
		#1;
		chk(16'(mem_we_o), 16'h0000, "strobe width"); // Single pulse
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	// Every update mode at the end of the pointer range where it wraps, then the offset bounds.
	task automatic test_store_modes();
		set_ptr(1'b0, 16'hffff);
		do_store(1'b0, 1'b0, MODE_PRE_INC, 6'h00, 16'h0000, 16'h0000); // Wrap up
		do_store(1'b0, 1'b0, MODE_PRE_DEC, 6'h00, 16'hffff, 16'hffff); // Wrap down
		do_store(1'b0, 1'b0, MODE_POST_INC, 6'h00, 16'hffff, 16'h0000); // Post wrap
		do_store(1'b0, 1'b0, MODE_POST_DEC, 6'h00, 16'h0000, 16'hffff); // Post wrap
		set_ptr(1'b1, 16'h0010);
		do_store(1'b1, 1'b1, 2'h3, 6'h20, 16'hfff0, 16'h0010); // Lowest offset
		do_store(1'b1, 1'b1, 2'h0, 6'h1f, 16'h002f, 16'h0010); // Highest offset
		chk(file_select_pointer0_o, 16'hffff, "other pointer"); // Index selects one
	endtask

	// A load, with a store offered while the decode port is closed; the store must vanish.
	task automatic do_load(input logic sel, input logic [1:0] md, input logic [7:0] rd,
		input logic [15:0] exp_addr, input logic [15:0] exp_ptr, input logic exp_z);
		@(posedge ref_clk_i);
		mem_rdata_i <= rd;
		instr_valid_i <= 1'b1;
		instr_op_i <= OP_LOAD_IND;
		ptr_sel_i <= sel;
		rel_form_i <= 1'b0;
		pointer_update_mode_i <= md;
		// Valid stays high so that a store is offered while the port is closed.
		@(posedge ref_clk_i);
		instr_op_i <= OP_STORE_IND;
		#1;
		chk(16'({mem_re_o, ready_o}), 16'h0002, "read strobe"); // Load reads
		chk(mem_addr_o, exp_addr, "load address"); // Same modes
		chk(sel ? file_select_pointer1_o : file_select_pointer0_o, exp_ptr, "load pointer"); // Update
		@(posedge ref_clk_i);
		instr_valid_i <= 1'b0;
		#1;
		chk(16'({acc_we_o, zero_we_o, ready_o, mem_we_o}), 16'h000e, "load result"); // Refused store
		chk(16'({acc_wdata_o, zero_o}), 16'({rd, exp_z}), "load value"); // Zero flag
		@(posedge ref_clk_i);
		#1;
		chk(16'({acc_we_o, mem_we_o}), 16'h0000, "load tail"); // Single pulse
	endtask

	task automatic test_load();
		set_ptr(1'b1, 16'hffff);
		do_load(1'b1, MODE_POST_INC, 8'h00, 16'hffff, 16'h0000, 1'b1); // Zero result
		set_ptr(1'b0, 16'h0000);
		do_load(1'b0, MODE_PRE_DEC, 8'h81, 16'hffff, 16'hffff, 1'b0); // Nonzero result
	endtask

	// Alias accesses reach memory at the pointer; a read is not answered locally.
	task automatic test_port();
		set_ptr(1'b1, 16'h1234);
		@(posedge ref_clk_i);
		port_access_i <= 1'b1;
		port_sel_i <= 1'b1;
		port_write_i <= 1'b1;
		port_wdata_i <= 8'ha5;
		@(posedge ref_clk_i);
		port_write_i <= 1'b0;
		#1;
		chk(16'({mem_we_o, mem_wdata_o}), 16'h01a5, "alias write"); // Redirected
		chk(mem_addr_o, 16'h1234, "alias address"); // Pointed location
		@(posedge ref_clk_i);
		port_access_i <= 1'b0;
		#1;
		chk(16'({mem_re_o, mem_we_o, acc_we_o}), 16'h0004, "alias read"); // No local storage
		chk(file_select_pointer1_o, 16'h1234, "alias keeps ptr"); // Pointer kept
	endtask

	// A no-operation changes nothing, and an alias access beside it is ignored.
	task automatic test_nop();
		// The alias request rises on the same edge as the no-operation, never alone before it.
		@(posedge ref_clk_i);
		port_access_i <= 1'b1;
		port_write_i <= 1'b1;
		instr_valid_i <= 1'b1;
		instr_op_i <= OP_NO_OPERATION;
		@(posedge ref_clk_i);
		port_access_i <= 1'b0;
		instr_valid_i <= 1'b0;
		#1;
		chk(16'({mem_we_o, mem_re_o, acc_we_o, zero_we_o, soft_reset_o}), 16'h0000, "nop pulses"); // Idle
		chk(file_select_pointer1_o, 16'h1234, "nop pointer"); // Unchanged
		chk(file_select_pointer0_o, 16'hffff, "nop pointer 0"); // Unchanged
		chk(16'(ready_o), 16'h0001, "nop ready"); // One cycle
	endtask

	// Software reset pulses both requests together, and the device reset clears pointers.
	task automatic test_soft_reset();
		issue(OP_SOFT_RESET, 1'b0, 1'b0, 2'h0, 6'h00, 8'h00);
		chk(16'(soft_reset_o), 16'h0001, "reset request"); // Device reset
		chk(16'(reset_instruction_flag_clr_o), 16'h0001, "flag clear"); // Cause flag
		@(posedge ref_clk_i);
		rst_i <= 1'b1;
		#1;
		chk(16'({soft_reset_o, reset_instruction_flag_clr_o}), 16'h0000, "reset width"); // Pulse
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		#1;
		chk(file_select_pointer1_o, 16'h0000, "pointer reset"); // Full reset
		chk(16'(ready_o), 16'h0001, "ready reset"); // Full reset
	endtask

	// ------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------
	// Reset is held for six cycles before the scenarios run.
	initial
	begin
		repeat (6) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		#1;
		chk(file_select_pointer0_o, 16'h0000, "initial pointer"); // Reset value
		test_store_modes();
		test_load();
		test_port();
		test_nop();
		test_soft_reset();
		conclude();
	end

	// The scenarios need about 50 cycles; 2000 leaves ample margin before a hang is declared.
	initial
	begin
		repeat (2000) @(posedge ref_clk_i);
		n_fail++;
		conclude();
	end
endmodule
`default_nettype wire
